/* File: ead_pkg.sv */
// Package for the eight-bit arithmetic and logic datapath.
// Holds operation codes, carrier structs, cycle counts and reset values.
// Assumes the decoder and register file share the core clock.
`default_nettype none

package ead_pkg;

  localparam logic [1:0] EAD_CYC_SINGLE = 2'h1;
  localparam logic [1:0] EAD_CYC_DOUBLE = 2'h2;
  localparam logic [15:0] EAD_RST_RESULT = 16'h0000;
  localparam logic [7:0] EAD_ALL_ONES = 8'hFF;
  localparam logic [7:0] EAD_SIGN_MIN = 8'h80;
  localparam logic [7:0] EAD_SIGN_MAX = 8'h7F;
  localparam int EAD_WORD_K_MSB = 5;

  typedef enum logic [4:0] {
    OP_PLUS_REGS = 5'h00,
    OP_PLUS_WITH_CARRY = 5'h01,
    OP_WORD_PLUS_IMMEDIATE = 5'h02,
    OP_MINUS = 5'h03,
    OP_MINUS_WITH_BORROW = 5'h04,
    OP_WORD_MINUS_IMMEDIATE = 5'h05,
    OP_CONJUNCTION = 5'h06,
    OP_DISJUNCTION = 5'h07,
    OP_EXCLUSIVE_DISJUNCTION_REGS = 5'h08,
    OP_ONES_INVERSION = 5'h09,
    OP_TWOS_INVERSION = 5'h0A,
    OP_SET_BITS_MASK = 5'h0B,
    OP_CLEAR_BITS_MASK = 5'h0C,
    OP_PLUS_ONE = 5'h0D,
    OP_MINUS_ONE = 5'h0E,
    OP_ZERO_SIGN_CHECK = 5'h0F,
    OP_ZERO_REGISTER_FILL = 5'h10,
    OP_ALL_ONES_FILL = 5'h11,
    OP_UNSIGNED_PRODUCT = 5'h12,
    OP_SIGNED_PRODUCT = 5'h13,
    OP_MIXED_SIGN_PRODUCT = 5'h14,
    OP_FRACTIONAL_UNSIGNED_PRODUCT = 5'h15,
    OP_FRACTIONAL_SIGNED_PRODUCT = 5'h16,
    OP_FRACTIONAL_MIXED_PRODUCT = 5'h17
  } ead_op_t;

  typedef enum logic [1:0] {
    EAD_WR_NONE = 2'h0,
    EAD_WR_RD = 2'h1,
    EAD_WR_PAIR = 2'h2,
    EAD_WR_R1R0 = 2'h3
  } ead_wr_t;

  typedef enum logic [1:0] {
    EAD_ST_IDLE = 2'b01,
    EAD_ST_HOLD = 2'b10
  } ead_state_t;

  typedef struct packed {
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } ead_flags_t;

  typedef struct packed {
    logic valid;
    ead_op_t op;
    logic [7:0] rd_val;
    logic [7:0] rr_val;
    logic [15:0] pair_val;
    ead_flags_t flags;
  } ead_req_t;

  typedef struct packed {
    logic done;
    logic busy;
    ead_wr_t wr;
    logic [15:0] result;
    ead_flags_t flags;
  } ead_rsp_t;

  typedef struct packed {
    ead_state_t st;
    logic [1:0] cnt;
    ead_rsp_t rsp;
    ead_rsp_t held;
  } ead_regs_t;

endpackage : ead_pkg

`default_nettype wire

/* File: ead_datapath.sv */
// Eight-bit arithmetic and logic datapath with a two-cycle multiplier.
// Assumes the decoder holds no request while busy is high and that
// operands and flags come from logic on the same clock.
`default_nettype none

// Function
// - Add two registers, optionally plus carry; update Z C N V H; one cycle.
// - Add immediate to register pair as one word; update Z C N V S; two cycles.
// - Subtract register or constant; store difference; update Z C N V H; one cycle.
// - Subtract with borrow, register or constant; update Z C N V H; one cycle.
// - Subtract immediate from register pair as word; update Z C N V S; two cycles.
// - AND with register or constant; update Z N V only; one cycle.
// - OR with register or constant; update Z N V only; one cycle.
// - Exclusive OR of two registers; update Z N V; one cycle.
// - Set bits ORs mask, clear bits ANDs complement; Z N V; one cycle.
// - Test ANDs register with itself, value unchanged; Z N V; one cycle.
// - Product unsigned, signed or mixed into R1:R0; Z and C; two cycles.
// - Fractional products shift left one before R1:R0; Z and C; two cycles.
module ead_datapath
  import ead_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire ead_req_t req,
  output ead_rsp_t rsp
);

  ead_regs_t q_reg;
  ead_regs_t q_next;

  ////////////////////////////////////////////////////////////////////////////
  // Operation result and flags

  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] r8;
  logic [15:0] r16;
  logic [8:0] s9;
  logic [16:0] w17;
  logic [15:0] ax;
  logic [15:0] bx;
  logic [31:0] p32;
  logic cin;
  logic upd_nz;
  logic two_cyc;
  ead_flags_t f;
  ead_wr_t wr;

  always_comb begin
    a = req.rd_val;
    b = req.rr_val;
    cin = 1'b0;
    r8 = 8'h00;
    r16 = EAD_RST_RESULT;
    s9 = 9'h000;
    w17 = 17'h0_0000;
    ax = 16'h0000;
    bx = 16'h0000;
    p32 = 32'h0000_0000;
    upd_nz = 1'b1;
    two_cyc = 1'b0;
    f = req.flags;
    wr = EAD_WR_RD;
    case (req.op)
      OP_PLUS_REGS, OP_PLUS_WITH_CARRY: begin
        cin = (req.op == OP_PLUS_WITH_CARRY) ? req.flags.c : 1'b0;
        s9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        r8 = s9[7:0];
        f.c = s9[8];
        f.h = (a[3] & b[3]) | (b[3] & ~r8[3]) | (~r8[3] & a[3]);
        f.v = (a[7] & b[7] & ~r8[7]) | (~a[7] & ~b[7] & r8[7]);
      end
      OP_MINUS, OP_MINUS_WITH_BORROW: begin
        cin = (req.op == OP_MINUS_WITH_BORROW) ? req.flags.c : 1'b0;
        s9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        r8 = s9[7:0];
        f.c = (~a[7] & b[7]) | (b[7] & r8[7]) | (r8[7] & ~a[7]);
        f.h = (~a[3] & b[3]) | (b[3] & r8[3]) | (r8[3] & ~a[3]);
        f.v = (a[7] & ~b[7] & ~r8[7]) | (~a[7] & b[7] & r8[7]);
      end
      OP_WORD_PLUS_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE: begin
        upd_nz = 1'b0;
        two_cyc = 1'b1;
        wr = EAD_WR_PAIR;
        if (req.op == OP_WORD_PLUS_IMMEDIATE) begin
          w17 = {1'b0, req.pair_val} + {11'h000, b[EAD_WORD_K_MSB:0]};
          r16 = w17[15:0];
          f.v = ~req.pair_val[15] & r16[15];
          f.c = ~r16[15] & req.pair_val[15];
        end else begin
          w17 = {1'b0, req.pair_val} - {11'h000, b[EAD_WORD_K_MSB:0]};
          r16 = w17[15:0];
          f.v = req.pair_val[15] & ~r16[15];
          f.c = r16[15] & ~req.pair_val[15];
        end
        f.n = r16[15];
        f.z = (r16 == 16'h0000);
        f.s = f.n ^ f.v;
      end
      OP_CONJUNCTION: begin
        r8 = a & b;
        f.v = 1'b0;
      end
      OP_DISJUNCTION: begin
        r8 = a | b;
        f.v = 1'b0;
      end
      OP_EXCLUSIVE_DISJUNCTION_REGS: begin
        r8 = a ^ b;
        f.v = 1'b0;
      end
      OP_SET_BITS_MASK: begin
        r8 = a | b;
        f.v = 1'b0;
      end
      OP_CLEAR_BITS_MASK: begin
        r8 = a & (EAD_ALL_ONES - b);
        f.v = 1'b0;
      end
      OP_ZERO_SIGN_CHECK: begin
        r8 = a & a;
        f.v = 1'b0;
        wr = EAD_WR_NONE;
      end
      OP_ONES_INVERSION: begin
        r8 = EAD_ALL_ONES - a;
        f.c = 1'b1;
        f.v = 1'b0;
      end
      OP_TWOS_INVERSION: begin
        r8 = 8'h00 - a;
        f.c = (r8 != 8'h00);
        f.v = (r8 == EAD_SIGN_MIN);
        f.h = r8[3] | a[3];
      end
      OP_PLUS_ONE: begin
        r8 = a + 8'h01;
        f.v = (r8 == EAD_SIGN_MIN);
      end
      OP_MINUS_ONE: begin
        r8 = a - 8'h01;
        f.v = (r8 == EAD_SIGN_MAX);
      end
      OP_ZERO_REGISTER_FILL: begin
        r8 = a ^ a;
        f.v = 1'b0;
      end
      OP_ALL_ONES_FILL: begin
        r8 = EAD_ALL_ONES;
        upd_nz = 1'b0;
      end
      OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
      OP_FRACTIONAL_UNSIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT,
      OP_FRACTIONAL_MIXED_PRODUCT: begin
        upd_nz = 1'b0;
        two_cyc = 1'b1;
        wr = EAD_WR_R1R0;
        ax = {8'h00, a};
        bx = {8'h00, b};
        if (req.op == OP_SIGNED_PRODUCT || req.op == OP_FRACTIONAL_SIGNED_PRODUCT ||
            req.op == OP_MIXED_SIGN_PRODUCT || req.op == OP_FRACTIONAL_MIXED_PRODUCT) begin
          ax = {{8{a[7]}}, a};
        end
        if (req.op == OP_SIGNED_PRODUCT || req.op == OP_FRACTIONAL_SIGNED_PRODUCT) begin
          bx = {{8{b[7]}}, b};
        end
        p32 = ax * bx;
        f.c = p32[15];
        if (req.op == OP_FRACTIONAL_UNSIGNED_PRODUCT ||
            req.op == OP_FRACTIONAL_SIGNED_PRODUCT ||
            req.op == OP_FRACTIONAL_MIXED_PRODUCT) begin
          r16 = {p32[14:0], 1'b0};
        end else begin
          r16 = p32[15:0];
        end
        f.z = (r16 == 16'h0000);
      end
      default: begin
        upd_nz = 1'b0;
        wr = EAD_WR_NONE;
      end
    endcase
    if (upd_nz) begin
      r16 = {8'h00, r8};
      f.n = r8[7];
      if (req.op == OP_MINUS_WITH_BORROW) begin
        f.z = (r8 == 8'h00) & req.flags.z;
      end else begin
        f.z = (r8 == 8'h00);
      end
    end
    if (req.op == OP_ALL_ONES_FILL) begin
      r16 = {8'h00, r8};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing of single and double cycle operations

  always_comb begin
    q_next = q_reg;
    q_next.rsp.done = 1'b0;
    case (q_reg.st)
      EAD_ST_IDLE: begin
        if (req.valid) begin
          if (two_cyc) begin
            q_next.st = EAD_ST_HOLD;
            q_next.cnt = EAD_CYC_DOUBLE - EAD_CYC_SINGLE;
            q_next.rsp.busy = 1'b1;
            q_next.held.done = 1'b1;
            q_next.held.busy = 1'b0;
            q_next.held.wr = wr;
            q_next.held.result = r16;
            q_next.held.flags = f;
          end else begin
            q_next.rsp.done = 1'b1;
            q_next.rsp.busy = 1'b0;
            q_next.rsp.wr = wr;
            q_next.rsp.result = r16;
            q_next.rsp.flags = f;
          end
        end
      end
      EAD_ST_HOLD: begin
        q_next.cnt = q_reg.cnt - 2'h1;
        if (q_reg.cnt == EAD_CYC_SINGLE) begin
          q_next.st = EAD_ST_IDLE;
          q_next.rsp = q_reg.held;
        end
      end
      default: begin
        q_next.st = EAD_ST_IDLE;
        q_next.rsp.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      q_reg <= '{st: EAD_ST_IDLE, cnt: 2'h0,
                 rsp: '{done: 1'b0, busy: 1'b0, wr: EAD_WR_NONE,
                        result: EAD_RST_RESULT, flags: '0},
                 held: '{done: 1'b0, busy: 1'b0, wr: EAD_WR_NONE,
                         result: EAD_RST_RESULT, flags: '0}};
    end else begin
      q_reg <= q_next;
    end
  end

  assign rsp = q_reg.rsp;

endmodule : ead_datapath

`default_nettype wire

/* File: ead_placeholder_unused.sv */
// Intentionally empty companion file.
// Assumes nothing.
`default_nettype none
`default_nettype wire

/* File: ead_datapath_props.sv */
// Checker for the datapath ports.
// Assumes ead_pkg is compiled first.
`default_nettype none
module ead_datapath_props
  import ead_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire ead_req_t req,
  input wire ead_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic go;
  logic dbl;
  logic wop;
  logic lop;
  assign go = req.valid && !rsp.busy;
  assign wop = req.op inside {OP_WORD_PLUS_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE};
  assign lop = req.op inside {OP_CONJUNCTION, OP_DISJUNCTION};
  assign dbl = req.op inside {OP_WORD_PLUS_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE,
    [OP_UNSIGNED_PRODUCT:OP_FRACTIONAL_MIXED_PRODUCT]};
  //////////////////////////////////////////////////////////////////
  a_single_done: assert property (go && !dbl |=> rsp.done && !rsp.busy)
    else $error("single op late");
  a_double_walk: assert property (go && dbl |=>
    (rsp.busy && !rsp.done) ##1 (rsp.done && !rsp.busy))
    else $error("double op walk wrong");
  a_word_pair: assert property (go && wop |=> ##1
    rsp.wr == EAD_WR_PAIR && rsp.flags.h == $past(req.flags.h, 2))
    else $error("word op wrong");
  a_byte_dest: assert property (go && req.op == OP_MINUS |=> rsp.wr == EAD_WR_RD)
    else $error("byte dest wrong");
  a_add_sum: assert property (go && req.op == OP_PLUS_REGS |=>
    rsp.result[7:0] == $past(req.rd_val) + $past(req.rr_val) && rsp.result[15:8] == 8'h00)
    else $error("sum wrong");
  a_sub_borrow: assert property (go && req.op == OP_MINUS |=>
    rsp.flags.c == ($past(req.rd_val) < $past(req.rr_val)))
    else $error("borrow wrong");
  a_logic_keep: assert property (go && lop |=>
    !rsp.flags.v && rsp.flags.c == $past(req.flags.c) && rsp.flags.h == $past(req.flags.h))
    else $error("logic flags wrong");
  a_product_val: assert property (go && req.op == OP_UNSIGNED_PRODUCT |=> ##1
    rsp.result == $past(req.rd_val, 2) * $past(req.rr_val, 2) && rsp.wr == EAD_WR_R1R0)
    else $error("product wrong");
  a_fill_flags: assert property (go && req.op == OP_ALL_ONES_FILL |=>
    rsp.result == 16'h00ff && rsp.flags == $past(req.flags))
    else $error("fill wrong");
  a_test_nowrite: assert property (go && req.op == OP_ZERO_SIGN_CHECK |=>
    rsp.wr == EAD_WR_NONE && rsp.flags.z == ($past(req.rd_val) == 8'h00))
    else $error("test op wrong");
  a_hold_result: assert property (!rsp.done |->
    $stable(rsp.result) && $stable(rsp.flags))
    else $error("result not held");
endmodule : ead_datapath_props
//////////////////////////////////////////////////////////////////
bind ead_datapath ead_datapath_props u_ead_datapath_props (
  .core_clk(core_clk), .resetn(resetn), .req(req), .rsp(rsp));
`default_nettype wire

/* File: ead_decoder_model.sv */
// Decoder and register file stand-in.
// Assumes the bench raises valid for one request at a time.
`default_nettype none
module ead_decoder_model
  import ead_pkg::*;
(
  input wire ead_req_t cmd,
  output var ead_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle lines show the inverse pattern
  always_comb begin
    req = cmd.valid ? cmd : ead_req_t'(~cmd);
    req.valid = cmd.valid;
  end
endmodule : ead_decoder_model
`default_nettype wire

/* File: tb_ead_datapath.sv */
// Self-checking bench for the datapath.
// Assumes package, design, model and checker compiled first.
`default_nettype none
module tb_ead_datapath
  import ead_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    ead_op_t op;
    logic [15:0] x;
    ead_flags_t fi;
    logic [15:0] r;
    ead_flags_t fo;
  } ead_row_t;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  ead_req_t cmd = '0;
  ead_req_t req;
  ead_rsp_t rsp;
  int num_errors = 0;
  int comparisons = 0;
  ead_row_t rows [24] = '{
    '{OP_PLUS_REGS, 16'h0808, 6'h00, 16'h0010, 6'h20},
    '{OP_PLUS_WITH_CARRY, 16'h7f00, 6'h01, 16'h0080, 6'h2c},
    '{OP_WORD_PLUS_IMMEDIATE, 16'hffff, 6'h00, 16'h003e, 6'h01},
    '{OP_MINUS, 16'h0001, 6'h00, 16'h00ff, 6'h25},
    '{OP_MINUS_WITH_BORROW, 16'h1010, 6'h02, 16'h0000, 6'h02},
    '{OP_WORD_MINUS_IMMEDIATE, 16'h003f, 6'h00, 16'h0000, 6'h02},
    '{OP_CONJUNCTION, 16'hf03c, 6'h3f, 16'h0030, 6'h31},
    '{OP_DISJUNCTION, 16'h8001, 6'h00, 16'h0081, 6'h04},
    '{OP_EXCLUSIVE_DISJUNCTION_REGS, 16'haaaa, 6'h00, 16'h0000, 6'h02},
    '{OP_ONES_INVERSION, 16'h0000, 6'h00, 16'h00ff, 6'h05},
    '{OP_TWOS_INVERSION, 16'h8000, 6'h00, 16'h0080, 6'h0d},
    '{OP_SET_BITS_MASK, 16'h0180, 6'h00, 16'h0081, 6'h04},
    '{OP_CLEAR_BITS_MASK, 16'hffff, 6'h00, 16'h0000, 6'h02},
    '{OP_PLUS_ONE, 16'h7f00, 6'h01, 16'h0080, 6'h0d},
    '{OP_MINUS_ONE, 16'h8000, 6'h00, 16'h007f, 6'h08},
    '{OP_ZERO_SIGN_CHECK, 16'h8000, 6'h00, 16'h0080, 6'h04},
    '{OP_ZERO_REGISTER_FILL, 16'h5500, 6'h00, 16'h0000, 6'h02},
    '{OP_ALL_ONES_FILL, 16'h0000, 6'h2a, 16'h00ff, 6'h2a},
    '{OP_UNSIGNED_PRODUCT, 16'hffff, 6'h00, 16'hfe01, 6'h01},
    '{OP_SIGNED_PRODUCT, 16'hff01, 6'h00, 16'hffff, 6'h01},
    '{OP_MIXED_SIGN_PRODUCT, 16'hff02, 6'h00, 16'hfffe, 6'h01},
    '{OP_FRACTIONAL_UNSIGNED_PRODUCT, 16'h8080, 6'h00, 16'h8000, 6'h00},
    '{OP_FRACTIONAL_SIGNED_PRODUCT, 16'hc040, 6'h00, 16'he000, 6'h01},
    '{OP_FRACTIONAL_MIXED_PRODUCT, 16'h00ff, 6'h00, 16'h0000, 6'h02}};
  //////////////////////////////////////////////////////////////////
  ead_decoder_model u_ead_decoder_model (.cmd(cmd), .req(req));
  ead_datapath u_ead_datapath (.core_clk(core_clk), .resetn(resetn), .req(req), .rsp(rsp));
  always #20 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic issue(input ead_op_t op, input logic [15:0] x, input ead_flags_t fi);
    int n = 0;
    @(posedge core_clk);
    cmd <= '{1'b1, op, x[15:8], x[7:0], x, fi};
    @(posedge core_clk);
    cmd.valid <= 1'b0;
    #1;
    while (rsp.done !== 1'b1 && n < 4) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check({15'h0000, rsp.done}, 16'h0001);
  endtask : issue
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  //////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 2000);
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      issue(rows[i].op, rows[i].x, rows[i].fi);
      check(rsp.result, rows[i].r);
      check({10'h000, rsp.flags}, {10'h000, rows[i].fo});
      $display("row %0d done", i);
    end
    // Back to back single ops
    @(posedge core_clk);
    cmd <= '{1'b1, OP_PLUS_REGS, 8'h01, 8'h02, 16'h0000, 6'h00};
    @(posedge core_clk);
    cmd <= '{1'b1, OP_DISJUNCTION, 8'h10, 8'h01, 16'h0000, 6'h00};
    #1 check(rsp.result, 16'h0003);
    @(posedge core_clk);
    cmd.valid <= 1'b0;
    #1 check(rsp.result, 16'h0011);
    $display("back to back done");
    // Request while busy is ignored
    @(posedge core_clk);
    cmd <= '{1'b1, OP_UNSIGNED_PRODUCT, 8'hff, 8'hff, 16'h0000, 6'h00};
    @(posedge core_clk);
    cmd <= '{1'b1, OP_PLUS_REGS, 8'h01, 8'h02, 16'h0000, 6'h00};
    @(posedge core_clk);
    cmd.valid <= 1'b0;
    #1 check(rsp.result, 16'hfe01);
    @(posedge core_clk);
    #1 check({15'h0000, rsp.done}, 16'h0000);
    $display("busy refusal done");
    // Reset in mid-run
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 check(rsp.result, 16'h0000);
    check({10'h000, rsp.flags}, 16'h0000);
    check({12'h000, rsp.done, rsp.busy, rsp.wr}, 16'h0000);
    @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    #1 check({15'h0000, rsp.done}, 16'h0000);
    issue(OP_MINUS, 16'h0503, 6'h00);
    check(rsp.result, 16'h0002);
    check({10'h000, rsp.flags}, 16'h0000);
    check({14'h0000, rsp.wr}, {14'h0000, EAD_WR_RD});
    $display("reset done");
    // Unknown code keeps flags and writes nothing
    issue(ead_op_t'(5'h1F), 16'h1234, 6'h15);
    check({10'h000, rsp.flags}, 16'h0015);
    check({14'h0000, rsp.wr}, {14'h0000, EAD_WR_NONE});
    $display("unknown code done");
    print_verdict();
  end
endmodule : tb_ead_datapath
`default_nettype wire
